//--- hw/tbs_supervisor.sv
// Thermal and boot supervisor: mode control, boot sequencing, thermal action
// Notes on behaviour
// - Enable pin below off level holds shutdown
// - Active only with enable and supply good
// - Measure config resistor index before loading
// - Successful load makes device ready, configured
// - Load failure leaves only first port enabled
// - Index eight selects update mode
// - ORed regulator sensors disable regulator, recover
// - Port A cable-power overtemp opens switch, recover
// - Port B overtemp acts only on dual-port
// - Discharge overtemp opens switch, conditional reclose
// - Master regulator overtemp disables, resets processor
// - Three temperature levels give policy responses
// - Enable above operate threshold starts startup
`timescale 1ns/1ps
module tbs_supervisor #(
  parameter bit DUAL_PORT = 1'b1
) (
  // Clock, reset, enable
  input  wire logic                           clk_in,
  input  wire logic                           rst_n_in,
  input  wire logic                           clk_en_in,
  // Comparator inputs (asynchronous)
  input  wire logic                           enable_operate_in,
  input  wire logic                           supply_lockout_ok_in,
  input  wire logic [tbs_pkg::TEMP_LEVELS-1:0] temp_level_in,
  // Thermal sensors (asynchronous)
  input  wire logic [1:0]                     regulator_switch_overtemp_in,
  input  wire logic                           port_a_cable_power_overtemp_in,
  input  wire logic                           port_b_cable_power_overtemp_in,
  input  wire logic                           port_a_discharge_overtemp_in,
  input  wire logic                           master_regulator_overtemp_in,
  // Discharge control from firmware
  input  wire logic                           discharge_request_in,
  input  wire logic                           bus_above_discharge_in,
  // Boot interface
  input  wire logic                           measure_done_in,
  input  wire logic [tbs_pkg::CFG_INDEX_W-1:0] config_index_in,
  input  wire logic                           load_done_in,
  input  wire logic                           load_error_in,
  // Mode and processor outputs
  output logic                                active_out,
  output logic                                processor_run_out,
  output logic                                measure_start_out,
  output logic                                load_start_out,
  output logic                                ready_out,
  output logic                                update_mode_out,
  output logic [tbs_pkg::CFG_INDEX_W-1:0]      config_index_out,
  output logic                                port_a_enable_out,
  output logic                                port_b_enable_out,
  // Switch, recovery and temperature policy outputs
  output logic                                regulator_enable_out,
  output logic                                port_a_cable_power_enable_out,
  output logic                                port_b_cable_power_enable_out,
  output logic                                port_a_discharge_enable_out,
  output logic                                error_recovery_out,
  output logic [tbs_pkg::TEMP_LEVELS-1:0]      temp_policy_out
);
  import tbs_pkg::*;

  // Eight single sensor and comparator bits plus the temperature levels
  localparam int unsigned NSYNC = 8 + TEMP_LEVELS;

  // Synchroniser stages; stage one is read only by stage two
  logic [NSYNC-1:0] sync1, sync2, next_sync1, next_sync2;
  logic [NSYNC-1:0] raw;

  always_comb begin
    raw = {temp_level_in, regulator_switch_overtemp_in,
           port_a_cable_power_overtemp_in, port_b_cable_power_overtemp_in,
           port_a_discharge_overtemp_in, master_regulator_overtemp_in,
           enable_operate_in, supply_lockout_ok_in};
    next_sync1 = raw;
    next_sync2 = sync1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (clk_en_in) begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  // Named views of the synchronised inputs
  logic       s_sup, s_en, s_master, s_dis, s_pb, s_pa, s_reg;
  logic [TEMP_LEVELS-1:0] s_temp;
  always_comb begin
    s_sup    = sync2[0];
    s_en     = sync2[1];
    s_master = sync2[2];
    s_dis    = sync2[3];
    s_pb     = sync2[4] & DUAL_PORT;
    s_pa     = sync2[5];
    s_reg    = sync2[6] | sync2[7];
    s_temp   = sync2[NSYNC-1:8];
  end

  // Power good: enable pin above operate level, supply above lockout,
  // and no master overtemp. Enable hysteresis lives in the comparator.
  logic power_good;
  always_comb begin
    power_good = s_en & s_sup & ~s_master;
  end

  // Boot sequencer
  tbs_state_e state, next_state;
  logic [CFG_INDEX_W-1:0] index_q, next_index;

  always_comb begin
    next_state = state;
    next_index = index_q;
    if (!power_good) begin
      next_state = TBS_SHUTDOWN;
    end else begin
      unique case (state)
        TBS_SHUTDOWN: next_state = TBS_MEASURE;
        TBS_MEASURE: begin
          if (measure_done_in) begin
            next_index = config_index_in;
            if (config_index_in == CFG_INDEX_UPDATE) begin
              next_state = TBS_UPDATE;
            end else begin
              next_state = TBS_LOAD;
            end
          end
        end
        TBS_LOAD: begin
          if (load_error_in) begin
            next_state = TBS_FALLBACK;
          end else if (load_done_in) begin
            next_state = TBS_READY;
          end
        end
        TBS_READY:    next_state = TBS_READY;
        TBS_FALLBACK: next_state = TBS_FALLBACK;
        TBS_UPDATE:   next_state = TBS_UPDATE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state   <= TBS_SHUTDOWN;
      index_q <= '0;
    end else if (clk_en_in) begin
      state   <= next_state;
      index_q <= next_index;
    end
  end

  // Output registers
  logic       prev_reg, prev_pa, prev_pb;
  logic       next_prev_reg, next_prev_pa, next_prev_pb;
  logic       next_active, next_run, next_meas, next_load, next_ready;
  logic       next_upd, next_pa_en, next_pb_en, next_reg_en, next_pa_vc;
  logic       next_pb_vc, next_dis_en, next_recov;
  logic [TEMP_LEVELS-1:0] next_policy;

  always_comb begin
    next_prev_reg = s_reg;
    next_prev_pa  = s_pa;
    next_prev_pb  = s_pb;
    next_active   = (next_state != TBS_SHUTDOWN);
    next_run      = next_active;
    next_meas     = (next_state == TBS_MEASURE);
    next_load     = (next_state == TBS_LOAD);
    next_ready    = (next_state == TBS_READY);
    next_upd      = (next_state == TBS_UPDATE);
    next_pa_en    = next_ready | next_upd |
                    (next_state == TBS_FALLBACK);
    next_pb_en    = next_ready & DUAL_PORT;
    next_reg_en   = next_active & ~s_reg;
    next_pa_vc    = next_pa_en & ~s_pa;
    next_pb_vc    = next_pb_en & ~s_pb;
    // Reclose only when cool and bus still above firmware threshold
    next_dis_en   = next_active & discharge_request_in &
                    ~s_dis & bus_above_discharge_in;
    // One pulse per fault onset; a held fault does not repeat it. An onset
    // in the cycle right after a pulse is already covered by that recovery,
    // so it is merged instead of stretching the pulse to two cycles.
    next_recov    = next_active & ~error_recovery_out &
                    ((s_reg & ~prev_reg) | (s_pa & ~prev_pa) |
                     (s_pb & ~prev_pb));
    next_policy   = next_active ? s_temp : '0;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_reg                      <= RST_OFF;
      prev_pa                       <= RST_OFF;
      prev_pb                       <= RST_OFF;
      active_out                    <= RST_OFF;
      processor_run_out             <= RST_OFF;
      measure_start_out             <= RST_OFF;
      load_start_out                <= RST_OFF;
      ready_out                     <= RST_OFF;
      update_mode_out               <= RST_OFF;
      config_index_out              <= '0;
      port_a_enable_out             <= RST_OFF;
      port_b_enable_out             <= RST_OFF;
      regulator_enable_out          <= RST_OFF;
      port_a_cable_power_enable_out <= RST_OFF;
      port_b_cable_power_enable_out <= RST_OFF;
      port_a_discharge_enable_out   <= RST_OFF;
      error_recovery_out            <= RST_OFF;
      temp_policy_out               <= '0;
    end else if (clk_en_in) begin
      prev_reg                      <= next_prev_reg;
      prev_pa                       <= next_prev_pa;
      prev_pb                       <= next_prev_pb;
      active_out                    <= next_active;
      processor_run_out             <= next_run;
      measure_start_out             <= next_meas;
      load_start_out                <= next_load;
      ready_out                     <= next_ready;
      update_mode_out               <= next_upd;
      config_index_out              <= next_index;
      port_a_enable_out             <= next_pa_en;
      port_b_enable_out             <= next_pb_en;
      regulator_enable_out          <= next_reg_en;
      port_a_cable_power_enable_out <= next_pa_vc;
      port_b_cable_power_enable_out <= next_pb_vc;
      port_a_discharge_enable_out   <= next_dis_en;
      error_recovery_out            <= next_recov;
      temp_policy_out               <= next_policy;
    end
  end

endmodule : tbs_supervisor

//--- hw/tbs_pkg.sv
// Package with constants and types for the thermal and boot supervisor
package tbs_pkg;

  // Configuration resistor index width and the reserved update index
  localparam int unsigned CFG_INDEX_W      = 4;
  localparam logic [3:0]  CFG_INDEX_UPDATE = 4'h8;

  // Number of temperature policy levels
  localparam int unsigned TEMP_LEVELS = 3;

  // Reset values of the outputs
  localparam logic        RST_OFF = 1'b0;

  // Boot sequencer states
  typedef enum logic [2:0] {
    TBS_SHUTDOWN,
    TBS_MEASURE,
    TBS_LOAD,
    TBS_READY,
    TBS_FALLBACK,
    TBS_UPDATE
  } tbs_state_e;

endpackage : tbs_pkg

//--- sim/tbs_supervisor_sva.sv
// Port-level checker for the thermal and boot supervisor
`timescale 1ns/1ps
module tbs_supervisor_sva #(
  parameter bit DUAL_PORT = 1'b1
) (
  // Clock, reset and inputs
  input wire logic       clk_in, rst_n_in, clk_en_in, enable_operate_in,
  input wire logic [1:0] regulator_switch_overtemp_in,
  input wire logic       port_a_cable_power_overtemp_in,
  input wire logic       master_regulator_overtemp_in,
  // Outputs
  input wire logic       active_out, processor_run_out, load_start_out,
  input wire logic       measure_start_out, ready_out, update_mode_out,
  input wire logic       port_b_enable_out, regulator_enable_out,
  input wire logic       port_a_cable_power_enable_out, error_recovery_out,
  input wire logic [tbs_pkg::CFG_INDEX_W-1:0] config_index_out
);
  import tbs_pkg::*;
  // Three enabled edges cover the synchroniser and output register
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_off_shuts: assert property (
    (clk_en_in && !enable_operate_in)[*3] |=> !active_out)
    else $error("active with enable low");
  a_master_resets: assert property (
    (clk_en_in && master_regulator_overtemp_in)[*3] |=> !processor_run_out)
    else $error("processor runs while hot");
  a_reg_off: assert property (
    (clk_en_in && |regulator_switch_overtemp_in)[*3]
    |=> !regulator_enable_out)
    else $error("regulator on while hot");
  a_cable_a_open: assert property (
    (clk_en_in && port_a_cable_power_overtemp_in)[*3]
    |=> !port_a_cable_power_enable_out)
    else $error("cable power on while hot");
  a_pulse_one: assert property (
    error_recovery_out && clk_en_in |=> !error_recovery_out)
    else $error("recovery longer than one cycle");
  a_measure_first: assert property (
    $rose(load_start_out) |-> $past(measure_start_out))
    else $error("load without measurement");
  a_port_b_ready: assert property (
    port_b_enable_out |-> ready_out && DUAL_PORT)
    else $error("second port outside ready");
  a_update_index: assert property (
    update_mode_out |-> config_index_out == CFG_INDEX_UPDATE && !ready_out)
    else $error("update mode with wrong index");
endmodule : tbs_supervisor_sva
bind tbs_supervisor tbs_supervisor_sva #(.DUAL_PORT(DUAL_PORT)) sva_inst (.*);

//--- sim/tbs_partner.sv
// Partner model: resistor measurement and EEPROM load answers
`timescale 1ns/1ps
module tbs_partner (
  // Clock, reset and scenario controls
  input  wire logic       clk_in, rst_n_in, fail_in,
  input  wire logic [3:0] index_in,
  // Requests
  input  wire logic       measure_start_in, load_start_in,
  // Answers
  output logic            md_out, ld_out, le_out,
  output logic [3:0]      ci_out
);
  logic [1:0] req, req_q;
  logic [2:0] cnt;
  // Answer on the fifth cycle of a request, so the design must wait
  assign req = {measure_start_in, load_start_in};
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {req_q, cnt, md_out, ld_out, le_out, ci_out} <= '0;
    end else begin
      req_q <= req;
      cnt <= (req != req_q) ? 3'h0 : cnt + 3'(cnt != 3'h7);
      md_out <= measure_start_in & (cnt == 3'h3);
      ld_out <= load_start_in & (cnt == 3'h3) & ~fail_in;
      le_out <= load_start_in & (cnt == 3'h3) & fail_in;
      // Index toggles outside the answer so stale data never matches
      ci_out <= (measure_start_in & (cnt == 3'h3)) ? index_in : ~ci_out;
    end
  end
endmodule : tbs_partner

//--- sim/tbs_supervisor_tb.sv
// Self-checking bench for the thermal and boot supervisor
`timescale 1ns/1ps
module tbs_supervisor_tb;
  import tbs_pkg::*;
  logic clk_in = 1'b0, rst_n_in = 1'b0, en = 1'b0, sup = 1'b1, fail = 1'b0;
  logic a_hot = 1'b0, b_hot = 1'b0, d_hot = 1'b0, m_hot = 1'b0, md, ld, le;
  logic d_req = 1'b0, bus_hi = 1'b0, act, run, ms, ls, rdy, upd, rec;
  logic pa, pb, ren, pac, pbc, pad;
  logic [1:0] r_hot = 2'h0;
  logic [2:0] temp = 3'h0, pol;
  logic [3:0] idx = 4'h3, ci, cio, exp_hot;
  int n_mismatch = 0, tests_run = 0, n_rec = 0, r0;
  // 125 MHz clock and recovery pulse counter
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) if (rec === 1'b1) n_rec++;
  tbs_supervisor tbs_supervisor_inst (.clk_in, .rst_n_in, .clk_en_in(1'b1),
    .enable_operate_in(en), .supply_lockout_ok_in(sup),
    .temp_level_in(temp), .regulator_switch_overtemp_in(r_hot),
    .port_a_cable_power_overtemp_in(a_hot),
    .port_b_cable_power_overtemp_in(b_hot),
    .port_a_discharge_overtemp_in(d_hot),
    .master_regulator_overtemp_in(m_hot), .discharge_request_in(d_req),
    .bus_above_discharge_in(bus_hi), .measure_done_in(md),
    .config_index_in(ci), .load_done_in(ld), .load_error_in(le),
    .active_out(act), .processor_run_out(run), .measure_start_out(ms),
    .load_start_out(ls), .ready_out(rdy), .update_mode_out(upd),
    .config_index_out(cio), .port_a_enable_out(pa), .port_b_enable_out(pb),
    .regulator_enable_out(ren), .port_a_cable_power_enable_out(pac),
    .port_b_cable_power_enable_out(pbc), .port_a_discharge_enable_out(pad),
    .error_recovery_out(rec), .temp_policy_out(pol));
  tbs_partner tbs_partner_inst (.clk_in, .rst_n_in, .fail_in(fail),
    .index_in(idx), .measure_start_in(ms), .load_start_in(ls),
    .md_out(md), .ld_out(ld), .le_out(le), .ci_out(ci));
  // Compare, count and report
  task automatic chk(input string nm, input logic [3:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic summarize();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Power up and wait, bounded, until the boot sequence settles
  task automatic boot(input logic [3:0] i, input logic f);
    @(posedge clk_in);
    idx <= i;
    fail <= f;
    en <= 1'b1;
    for (int k = 0; k < 60 && pa !== 1'b1; k++) tick(1);
    if (pa !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
  endtask : boot
  task automatic off();
    @(posedge clk_in);
    en <= 1'b0;
    tick(5);
    chk("shutdown", {act, run, ms, pa}, 4'h0);
  endtask : off
  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    sup <= 1'b0;
    en <= 1'b1;
    tick(8);
    chk("no supply", {ms, act, run, rdy}, 4'h0);
    @(posedge clk_in);
    en <= 1'b0;
    sup <= 1'b1;
    boot(4'h3, 1'b0);
    chk("ready", {rdy, pb, pac, pbc}, 4'hF);
    chk("index", cio, 4'h3);
    chk("run", {act, run, ren, upd}, 4'hE);
    // Each regulator and cable-power sensor in turn: one switch opens, one recovery pulse
    for (int k = 0; k < 4; k++) begin
      r0 = n_rec;
      @(posedge clk_in);
      r_hot <= 2'(k < 2 ? 1 << k : 0);
      a_hot <= (k == 2);
      b_hot <= (k == 3);
      tick(5);
      // Regulator sensors open the regulator, cable sensors their own switch
      exp_hot = (k < 2) ? 4'h3 : 4'h7 ^ (4'h1 << (3 - k));
      chk("hot", {1'b0, ren, pac, pbc}, exp_hot);
      @(posedge clk_in);
      {r_hot, a_hot, b_hot} <= 4'h0;
      tick(5);
      chk("cool", {1'b0, ren, pac, pbc}, 4'h7);
      chk("pulses", 4'(n_rec - r0), 4'h1);
    end
    // Discharge: cool, hot, cool again, then bus below threshold
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in);
      d_req <= 1'b1;
      {d_hot, bus_hi} <= 2'(8'h1D >> (2 * k));
      tick(5);
      chk("discharge", 4'(pad), 4'(k % 2 == 0));
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in);
      temp <= 3'((1 << k) - 1);
      tick(4);
      chk("policy", 4'(pol), 4'((1 << k) - 1));
    end
    @(posedge clk_in);
    m_hot <= 1'b1;
    tick(5);
    chk("master hot", {act, run, ren, pa}, 4'h0);
    @(posedge clk_in);
    m_hot <= 1'b0;
    boot(4'h3, 1'b0);
    chk("master cool", {rdy, act, run, pa}, 4'hF);
    off();
    boot(4'h5, 1'b1);
    chk("fallback", {rdy, pa, pb, pbc}, 4'h4);
    off();
    boot(CFG_INDEX_UPDATE, 1'b0);
    chk("update", {upd, rdy, ls, pb}, 4'h8);
    chk("update index", cio, CFG_INDEX_UPDATE);
    off();
    summarize();
  end
endmodule : tbs_supervisor_tb
